// ===== design/freq_measure.sv
`timescale 1ns/10ps
// Function
// - low-frequency mode: count timebase ticks across one period of the measured signal.
// - source is fast, mid or slow onboard timebase, or a routed known-rate signal.
// - counters pair fixed: zero with one, two with three.
// - high-frequency mode: count measured edges while known-width gate pulse is high.
// - gate pulse comes from paired counter or external terminal; external uses one counter.
// - large-range mode: first counter makes one pulse of N measured periods.
// - first counter output gates the second counter, which counts the timebase.
// - second counter does one pulse-width measurement giving J timebase periods.
// - averaging: embedded counts measured ticks, primary counts timebase, per sample.
// - non-averaging reports the last complete period before each sample clock edge.
// - averaging defaults on for buffered, off for hardware-timed single point.
// - hardware-timed single point supports both choices, averaging off by default.
// - large-range interval equals N periods of the measured input.
// - sample-clocked interval spans exactly one sample clock period.
// - flag overrun when no complete input pulse occurs between sample clocks.
module freq_measure #(
    parameter int          COUNT_WIDTH = freq_measure_pkg::COUNT_WIDTH,
    parameter logic [0:0]  PAIR_INDEX  = 1'b0
) (
    input  wire logic                          mclk,
    input  wire logic                          sys_rst,
    input  wire freq_measure_pkg::config_type  cfg,
    input  wire logic                          arm,
    input  wire logic                          disarm,
    input  wire logic                          measuredSignal,
    input  wire logic                          timebaseFastTick,
    input  wire logic                          timebaseMidTick,
    input  wire logic                          timebaseSlowTick,
    input  wire logic                          routedSourceTick,
    input  wire logic                          programmableFunctionTerminal,
    input  wire logic                          sampleClock,
    output      logic                          busy,
    output      logic                          pairGateOut,
    output      logic                          overrunSeen,
    output      logic                          sampleLost,
    output      logic                          resultValid,
    input  wire logic                          resultReady,
    output      freq_measure_pkg::sample_type  resultData
);

    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        freq_measure_pkg::state_type            state;
        freq_measure_pkg::config_type           cfg;
        logic                                   measPrev;
        logic                                   gatePrev;
        logic                                   samplePrev;
        logic                                   pairGate;
        logic [COUNT_WIDTH-1:0]                 pairCount;
        logic [COUNT_WIDTH-1:0]                 primary;
        logic [COUNT_WIDTH-1:0]                 embedded;
        logic [COUNT_WIDTH-1:0]                 lastPeriod;
        logic                                   periodStarted;
        logic                                   periodDone;
        logic                                   intervalStarted;
        logic                                   overrun;
        logic                                   lost;
        freq_measure_pkg::sample_type           pending;
        logic [1:0]                             level;
        freq_measure_pkg::sample_type [1:0]     entry;
    } core_type;

    core_type state_q;
    core_type state_d;

    // ------------------------------------------------------------
    // combinational terms
    // ------------------------------------------------------------
    localparam int                     ID_WIDTH_L  = freq_measure_pkg::ID_WIDTH;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ONE_L = COUNT_WIDTH'(1);

    logic                          sourceTick;
    logic                          measRise;
    logic                          sampleRise;
    logic                          gateLevel;
    logic                          gateFall;
    logic                          avgEnable;
    logic                          bufInReady;
    logic                          pushValid;
    logic                          popFire;
    logic                          pushFire;
    logic [ID_WIDTH_L-1:0]         pairId;
    freq_measure_pkg::sample_type  pushData;

    always_comb begin
        unique case (state_q.cfg.sourceSel)
            freq_measure_pkg::SRC_TIMEBASE_FAST: sourceTick = timebaseFastTick;
            freq_measure_pkg::SRC_TIMEBASE_MID:  sourceTick = timebaseMidTick;
            freq_measure_pkg::SRC_TIMEBASE_SLOW: sourceTick = timebaseSlowTick;
            freq_measure_pkg::SRC_ROUTED:        sourceTick = routedSourceTick;
        endcase
    end

    // the primary counter of pair P is counter 2P, its partner 2P+1
    assign pairId     = {PAIR_INDEX, 1'b0};
    assign measRise   = measuredSignal & ~state_q.measPrev;
    assign sampleRise = sampleClock & ~state_q.samplePrev;
    // external gate leaves the partner counter free
    assign gateLevel  = state_q.cfg.externalGate ? programmableFunctionTerminal
                                                 : state_q.pairGate;
    assign gateFall   = state_q.gatePrev & ~gateLevel;
    // buffered default on, single point default off, either overridable
    assign avgEnable  = state_q.cfg.averagingOverride ? state_q.cfg.frequencyAveragingEnable
                      : (state_q.cfg.hwTimedSinglePointMode ? freq_measure_pkg::AVG_DEFAULT_SINGLE
                                                            : freq_measure_pkg::AVG_DEFAULT_BUFFERED);

    assign bufInReady = state_q.level != freq_measure_pkg::LEVEL_FULL;
    assign popFire    = resultReady && (state_q.level != freq_measure_pkg::LEVEL_EMPTY);

    always_comb begin
        pushValid = 1'b0;
        pushData  = state_q.pending;
        if (state_q.state == freq_measure_pkg::ST_PUSH) begin
            pushValid = 1'b1;
        end else if (state_q.state == freq_measure_pkg::ST_RUN && sampleRise && state_q.intervalStarted) begin
            pushValid              = 1'b1;
            pushData.counterId     = pairId;
            pushData.averaged      = avgEnable;
            // a period ending on this very edge still counts as complete
            pushData.overrun       = ~(state_q.periodDone | (measRise & state_q.periodStarted));
            if (avgEnable) begin
                pushData.primaryCount  = state_q.primary + (sourceTick ? COUNT_ONE_L : '0);
                pushData.embeddedCount = state_q.embedded + (measRise ? COUNT_ONE_L : '0);
            end else begin
                pushData.primaryCount  = (measRise & state_q.periodStarted)
                                       ? state_q.primary + (sourceTick ? COUNT_ONE_L : '0)
                                       : state_q.lastPeriod;
                pushData.embeddedCount = COUNT_ONE_L;
            end
        end
    end

    assign pushFire = pushValid & bufInReady;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_d            = state_q;
        state_d.measPrev   = measuredSignal;
        state_d.samplePrev = sampleClock;
        state_d.gatePrev   = gateLevel;

        // two-entry output buffer
        if (popFire) begin
            state_d.entry[0] = state_q.entry[1];
        end
        if (pushFire) begin
            if (state_q.level == freq_measure_pkg::LEVEL_EMPTY ||
                (state_q.level == freq_measure_pkg::LEVEL_ONE && popFire)) begin
                state_d.entry[0] = pushData;
            end else begin
                state_d.entry[1] = pushData;
            end
        end
        unique case ({pushFire, popFire})
            2'b10:   state_d.level = state_q.level + 2'h1;
            2'b01:   state_d.level = state_q.level - 2'h1;
            default: state_d.level = state_q.level;
        endcase

        unique case (state_q.state)
            freq_measure_pkg::ST_IDLE: begin
                if (arm) begin
                    state_d.cfg             = cfg;
                    state_d.primary         = freq_measure_pkg::COUNT_RESET;
                    state_d.embedded        = freq_measure_pkg::COUNT_RESET;
                    state_d.pairCount       = freq_measure_pkg::COUNT_RESET;
                    state_d.periodStarted   = 1'b0;
                    state_d.periodDone      = 1'b0;
                    state_d.intervalStarted = 1'b0;
                    state_d.overrun         = 1'b0;
                    state_d.lost            = 1'b0;
                    state_d.pairGate        = 1'b0;
                    state_d.gatePrev        = 1'b0;
                    if (cfg.mode == freq_measure_pkg::MODE_SAMPLE_CLOCKED) begin
                        state_d.state = freq_measure_pkg::ST_RUN;
                    end else begin
                        state_d.state = freq_measure_pkg::ST_ARMED;
                    end
                    // partner counter opens a known-width gate at once
                    if (cfg.mode == freq_measure_pkg::MODE_HIGH_FREQ && !cfg.externalGate) begin
                        state_d.pairGate  = 1'b1;
                        state_d.pairCount = cfg.gatePulseTicks;
                    end
                end
            end

            freq_measure_pkg::ST_ARMED: begin
                unique case (state_q.cfg.mode)
                    freq_measure_pkg::MODE_LOW_FREQ: begin
                        if (measRise) begin
                            state_d.state   = freq_measure_pkg::ST_COUNT;
                            state_d.primary = freq_measure_pkg::COUNT_RESET;
                        end
                    end
                    freq_measure_pkg::MODE_LARGE_RANGE: begin
                        if (measRise) begin
                            state_d.state     = freq_measure_pkg::ST_COUNT;
                            state_d.pairGate  = 1'b1;
                            state_d.embedded  = COUNT_ONE_L;
                            state_d.primary   = freq_measure_pkg::COUNT_RESET;
                        end
                    end
                    default: begin
                        // high-frequency: wait for the gate to go active
                        if (gateLevel) begin
                            state_d.state   = freq_measure_pkg::ST_COUNT;
                            state_d.primary = measRise ? COUNT_ONE_L : freq_measure_pkg::COUNT_RESET;
                        end
                    end
                endcase
                if (state_q.cfg.mode == freq_measure_pkg::MODE_HIGH_FREQ && !state_q.cfg.externalGate &&
                    sourceTick && state_q.pairCount != freq_measure_pkg::COUNT_RESET) begin
                    state_d.pairCount = state_q.pairCount - COUNT_ONE_L;
                end
            end

            freq_measure_pkg::ST_COUNT: begin
                state_d.pending.counterId = pairId;
                state_d.pending.overrun   = 1'b0;
                state_d.pending.averaged  = 1'b0;
                unique case (state_q.cfg.mode)
                    freq_measure_pkg::MODE_LOW_FREQ: begin
                        if (measRise) begin
                            // one gate period exactly, closing edge ends it
                            state_d.pending.primaryCount  = state_q.primary + (sourceTick ? COUNT_ONE_L : '0);
                            state_d.pending.embeddedCount = COUNT_ONE_L;
                            state_d.state                 = freq_measure_pkg::ST_PUSH;
                        end else if (sourceTick) begin
                            state_d.primary = state_q.primary + COUNT_ONE_L;
                        end
                    end
                    freq_measure_pkg::MODE_LARGE_RANGE: begin
                        if (sourceTick) begin
                            state_d.primary = state_q.primary + COUNT_ONE_L;
                        end
                        if (measRise) begin
                            if (state_q.embedded == state_q.cfg.divideDown) begin
                                // pulse closes after exactly N measured periods
                                state_d.pairGate              = 1'b0;
                                // closing edge cycle counts, as in low-frequency mode
                                state_d.pending.primaryCount  = state_q.primary + (sourceTick ? COUNT_ONE_L : '0);
                                state_d.pending.embeddedCount = state_q.embedded;
                                state_d.state                 = freq_measure_pkg::ST_PUSH;
                            end else begin
                                state_d.embedded = state_q.embedded + COUNT_ONE_L;
                            end
                        end
                    end
                    default: begin
                        if (!state_q.cfg.externalGate && sourceTick) begin
                            if (state_q.pairCount <= COUNT_ONE_L) begin
                                state_d.pairGate  = 1'b0;
                                state_d.pairCount = freq_measure_pkg::COUNT_RESET;
                            end else begin
                                state_d.pairCount = state_q.pairCount - COUNT_ONE_L;
                            end
                        end
                        if (gateFall) begin
                            state_d.pending.primaryCount  = state_q.primary;
                            state_d.pending.embeddedCount = state_q.cfg.gatePulseTicks;
                            state_d.state                 = freq_measure_pkg::ST_PUSH;
                        end else if (measRise) begin
                            state_d.primary = state_q.primary + COUNT_ONE_L;
                        end
                    end
                endcase
                if (disarm) begin
                    state_d.state    = freq_measure_pkg::ST_IDLE;
                    state_d.pairGate = 1'b0;
                end
            end

            freq_measure_pkg::ST_PUSH: begin
                // back-pressure holds the result until the buffer has room
                if (bufInReady) begin
                    state_d.state = freq_measure_pkg::ST_IDLE;
                end
            end

            freq_measure_pkg::ST_RUN: begin
                // period tracking for the single-period choice
                if (measRise) begin
                    state_d.periodStarted = 1'b1;
                    state_d.primary       = freq_measure_pkg::COUNT_RESET;
                    if (state_q.periodStarted) begin
                        state_d.lastPeriod = state_q.primary + (sourceTick ? COUNT_ONE_L : '0);
                        state_d.periodDone = 1'b1;
                    end
                end else if (sourceTick) begin
                    state_d.primary = state_q.primary + COUNT_ONE_L;
                end
                if (avgEnable) begin
                    if (measRise) begin
                        state_d.embedded = state_q.embedded + COUNT_ONE_L;
                    end
                    state_d.primary = state_q.primary + (sourceTick ? COUNT_ONE_L : '0);
                end
                if (sampleRise) begin
                    // interval restarts on each sample clock edge
                    state_d.intervalStarted = 1'b1;
                    state_d.periodDone      = 1'b0;
                    state_d.embedded        = freq_measure_pkg::COUNT_RESET;
                    if (avgEnable) begin
                        state_d.primary = freq_measure_pkg::COUNT_RESET;
                    end
                    if (pushValid && pushData.overrun) begin
                        state_d.overrun = 1'b1;
                    end
                    if (pushValid && !bufInReady) begin
                        state_d.lost = 1'b1;
                    end
                end
                if (disarm) begin
                    state_d.state = freq_measure_pkg::ST_IDLE;
                end
            end

            default: state_d.state = freq_measure_pkg::ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q       <= '0;
            state_q.state <= freq_measure_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign busy        = state_q.state != freq_measure_pkg::ST_IDLE;
    assign pairGateOut = state_q.pairGate;
    assign overrunSeen = state_q.overrun;
    assign sampleLost  = state_q.lost;
    assign resultValid = state_q.level != freq_measure_pkg::LEVEL_EMPTY;
    assign resultData  = state_q.entry[0];

endmodule

// ===== design/freq_measure_pkg.sv
package freq_measure_pkg;

    // ------------------------------------------------------------
    // widths and constants
    // ------------------------------------------------------------
    localparam int COUNT_WIDTH = 32;
    localparam int ID_WIDTH    = 2;

    // onboard timebase rates in Hz; the source strobes are assumed to tick at these
    localparam int TIMEBASE_FAST_HZ = 100_000_000;
    localparam int TIMEBASE_MID_HZ  = 20_000_000;
    localparam int TIMEBASE_SLOW_HZ = 100_000;

    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 32'h0000_0000;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ONE   = 32'h0000_0001;
    localparam logic [1:0]             LEVEL_EMPTY = 2'h0;
    localparam logic [1:0]             LEVEL_ONE   = 2'h1;
    localparam logic [1:0]             LEVEL_FULL  = 2'h2;
    localparam logic                   AVG_DEFAULT_BUFFERED = 1'b1;
    localparam logic                   AVG_DEFAULT_SINGLE   = 1'b0;

    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_LOW_FREQ,
        MODE_HIGH_FREQ,
        MODE_LARGE_RANGE,
        MODE_SAMPLE_CLOCKED
    } mode_type;

    typedef enum logic [1:0] {
        SRC_TIMEBASE_FAST,
        SRC_TIMEBASE_MID,
        SRC_TIMEBASE_SLOW,
        SRC_ROUTED
    } source_type;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ARMED,
        ST_COUNT,
        ST_RUN,
        ST_PUSH
    } state_type;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        mode_type               mode;
        source_type             sourceSel;
        logic                   externalGate;
        logic                   hwTimedSinglePointMode;
        logic                   averagingOverride;
        logic                   frequencyAveragingEnable;
        logic [COUNT_WIDTH-1:0] divideDown;
        logic [COUNT_WIDTH-1:0] gatePulseTicks;
    } config_type;

    typedef struct packed {
        logic [ID_WIDTH-1:0]    counterId;
        logic                   overrun;
        logic                   averaged;
        logic [COUNT_WIDTH-1:0] primaryCount;
        logic [COUNT_WIDTH-1:0] embeddedCount;
    } sample_type;

endpackage

// ===== tb/freq_measure_sva.sv
`timescale 1ns/10ps
module freq_measure_sva #(
    parameter logic [0:0] PAIR_INDEX = 1'b0
) (
    input wire logic                         mclk,
    input wire logic                         sys_rst,
    input wire logic                         arm,
    input wire logic                         busy,
    input wire logic                         pairGateOut,
    input wire logic                         overrunSeen,
    input wire logic                         sampleLost,
    input wire logic                         resultValid,
    input wire logic                         resultReady,
    input wire freq_measure_pkg::sample_type resultData
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    arm_starts_a: assert property (arm && !busy |=> busy) else $error("no busy after arm");
    word_held_a: assert property (resultValid && !resultReady |=> $stable(resultData))
        else $error("word changed while held");
    valid_held_a: assert property (resultValid && !resultReady |=> resultValid) else $error("word lost");
    gate_in_run_a: assert property (pairGateOut |-> busy) else $error("gate open while idle");
    overrun_sticky_a: assert property (overrunSeen && !arm |=> overrunSeen) else $error("overrun cleared");
    lost_sticky_a: assert property (sampleLost && !arm |=> sampleLost) else $error("loss flag cleared");
    arm_clears_a: assert property (arm && !busy |=> !overrunSeen && !sampleLost)
        else $error("flags kept over arm");
    pair_id_a: assert property (resultValid |-> resultData.counterId == {PAIR_INDEX, 1'b0})
        else $error("wrong counter id");
endmodule

// ===== tb/measured_signal_source.sv
`timescale 1ns/10ps
module measured_signal_source (
    input  wire logic mclk,
    input  wire logic sys_rst,
    input  wire logic runSig,
    output      logic measuredSignal,
    output      logic timebaseFastTick,
    output      logic timebaseMidTick,
    output      logic timebaseSlowTick,
    output      logic routedSourceTick,
    output      logic sampleClock
);
    // one shared 100-cycle phase keeps every tick and sample rising edge clear of measured rising edges
    logic [6:0] phase_q;
    always_ff @(posedge mclk) phase_q <= (sys_rst || phase_q == 7'h63) ? 7'h00 : phase_q + 7'h01;
    assign measuredSignal = runSig && (phase_q % 7'h14 < 7'h0a);
    assign timebaseFastTick = (phase_q % 7'h05 == 7'h02);
    assign timebaseMidTick = (phase_q % 7'h0a == 7'h02);
    assign timebaseSlowTick = (phase_q % 7'h14 == 7'h07);
    assign routedSourceTick = (phase_q % 7'h04 == 7'h02);
    assign sampleClock = (phase_q >= 7'h0a && phase_q < 7'h3c);
endmodule

// ===== tb/test_counter_frequency_measurement.sv
`timescale 1ns/10ps
module test_counter_frequency_measurement;
    logic mclk = 1'b0, sys_rst = 1'b1, arm = 1'b0, disarm = 1'b0, resultReady = 1'b0, runSig = 1'b1;
    logic programmableFunctionTerminal = 1'b0;
    freq_measure_pkg::config_type cfg = '0;
    freq_measure_pkg::sample_type resultData, w;
    logic measuredSignal, timebaseFastTick, timebaseMidTick, timebaseSlowTick, routedSourceTick, sampleClock;
    logic busy, pairGateOut, overrunSeen, sampleLost, resultValid;
    int mismatches = 0, checks = 0;
    measured_signal_source u_src (.mclk, .sys_rst, .runSig, .measuredSignal, .timebaseFastTick, .timebaseMidTick,
        .timebaseSlowTick, .routedSourceTick, .sampleClock);
    freq_measure u_dut (.mclk, .sys_rst, .cfg, .arm, .disarm, .measuredSignal, .timebaseFastTick, .timebaseMidTick,
        .timebaseSlowTick, .routedSourceTick, .programmableFunctionTerminal, .sampleClock, .busy, .pairGateOut,
        .overrunSeen, .sampleLost, .resultValid, .resultReady, .resultData);
    initial forever #2 mclk = ~mclk;
    // ----------------
    // helpers
    // ----------------
    task automatic tick(int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // flags: external gate, single point, override, averaging
    task automatic start(logic [1:0] m, logic [1:0] s, logic [3:0] f, logic [31:0] n);
        while (busy !== 1'b0) tick(1);
        cfg = '{freq_measure_pkg::mode_type'(m), freq_measure_pkg::source_type'(s), f[3], f[2], f[1], f[0], n, n};
        arm = 1'b1;
        tick(1);
        arm = 1'b0;
    endtask
    task automatic pop();
        int n = 0;
        while (resultValid !== 1'b1 && n < 3000) begin
            tick(1);
            n++;
        end
        w = resultData;
        resultReady = 1'b1;
        tick(1);
        resultReady = 1'b0;
        tick(1);
    endtask
    task automatic halt();
        disarm = 1'b1;
        tick(1);
        disarm = 1'b0;
        tick(2);
        while (resultValid === 1'b1) pop();
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic test_low();
        int rate[4] = '{4, 2, 1, 5};
        for (int s = 0; s < 4; s++) begin
            start(2'h0, s[1:0], 4'h0, 32'h0);
            pop();
            check("low period", w.primaryCount, rate[s]);
            check("low embedded", w.embeddedCount, 32'h1);
        end
        $display("test_low done");
    endtask
    task automatic test_high();
        start(2'h1, 2'h0, 4'h0, 32'h28);
        pop();
        check("high edges", 32'(w.primaryCount inside {[9:11]}), 32'h1);
        check("high gate ticks", w.embeddedCount, 32'h28);
        start(2'h1, 2'h0, 4'h8, 32'h28);
        programmableFunctionTerminal = 1'b1;
        tick(200);
        programmableFunctionTerminal = 1'b0;
        pop();
        check("external edges", 32'(w.primaryCount inside {[9:11]}), 32'h1);
        start(2'h2, 2'h0, 4'h0, 32'h4);
        tick(30);
        check("pair gate", {31'h0, pairGateOut}, 32'h1);
        pop();
        check("large ticks", w.primaryCount, 32'h10);
        check("large divide", w.embeddedCount, 32'h4);
        $display("test_high done");
    endtask
    task automatic test_sample();
        logic [3:0] f[3] = '{4'h0, 4'h4, 4'h7};
        logic [31:0] p[3] = '{32'h14, 32'h4, 32'h14};
        for (int i = 0; i < 3; i++) begin
            start(2'h3, 2'h0, f[i], 32'h0);
            pop();
            check("sample primary", w.primaryCount, p[i]);
            check("sample embedded", w.embeddedCount, (i == 1) ? 32'h1 : 32'h5);
            check("sample averaged", {31'h0, w.averaged}, (i == 1) ? 32'h0 : 32'h1);
            halt();
        end
        runSig = 1'b0;
        start(2'h3, 2'h0, 4'h0, 32'h0);
        tick(450);
        check("overrun flag", {31'h0, overrunSeen}, 32'h1);
        check("sample dropped", {31'h0, sampleLost}, 32'h1);
        pop();
        check("overrun word", {31'h0, w.overrun}, 32'h1);
        halt();
        check("buffer drained", {31'h0, resultValid}, 32'h0);
        $display("test_sample done");
    endtask
    initial begin
        tick(2);
        sys_rst = 1'b0;
        test_low();
        test_high();
        test_sample();
        stop_test();
    end
    initial begin
        #80000;
        mismatches++;
        stop_test();
    end
endmodule
bind freq_measure freq_measure_sva #(.PAIR_INDEX(PAIR_INDEX)) u_sva (.mclk, .sys_rst, .arm, .busy, .pairGateOut,
    .overrunSeen, .sampleLost, .resultValid, .resultReady, .resultData);
